// ==== include/mark_mode_pkg.sv ====
/*
 Constants, register map and instruction classes of the mark-mode,
 stack and register-bank control of a 4-bit core.
 Assumes a 12-bit data-memory address space with 4-bit registers and
 an instruction decoder outside that hands over one class per request.
*/
// What this block does
// - Stack bank bit 3 selects memory mode
// - Calls push two or three byte frames
// - Absolute call takes three or four cycles
// - Fixed-area call takes two or three cycles
// - Extended branch and call only large mode
// - Four register banks, instruction or register chosen
// - Pair-indirect branches and table reads, sixteen bit
// - Eight-bit stack pointer wraps within bank
// - Stack bank bits 1:0 choose memory bank
// - Stack bank register resets to 1000 binary
// - Status word adds bank-enable and interrupt bits
// - Single-bit moves reach the carry flag
// - Larger instruction set contains the older one
// - Reset wait is 2^15 or 2^17 clocks
// - Vectors load bank enable; zero keeps one bank
package mark_mode_pkg;

    localparam logic [11:0] ADDR_SP_LOW     = 12'hf80;
    localparam logic [11:0] ADDR_SP_HIGH    = 12'hf81;
    localparam logic [11:0] ADDR_BANK_SEL   = 12'hf82;
    localparam logic [11:0] ADDR_STACK_BANK = 12'hf84;
    localparam logic [11:0] ADDR_PSW        = 12'hfb0;

    localparam logic [3:0] STACK_BANK_RESET = 4'h8;
    localparam logic [3:0] BANK_SEL_RESET   = 4'h0;
    localparam logic [7:0] SP_RESET         = 8'h00;

    localparam int MODE_BIT    = 3;
    localparam int PSW_CARRY   = 0;
    localparam int PSW_IST     = 1;
    localparam int PSW_BANK_EN = 3;

    localparam logic [1:0] SMALL_FRAME = 2'h2;
    localparam logic [1:0] LARGE_FRAME = 2'h3;

    localparam logic [2:0] CALL_SMALL_CYCLES  = 3'h3;
    localparam logic [2:0] CALL_LARGE_CYCLES  = 3'h4;
    localparam logic [2:0] FCALL_SMALL_CYCLES = 3'h2;
    localparam logic [2:0] FCALL_LARGE_CYCLES = 3'h3;
    localparam logic [2:0] OTHER_CYCLES       = 3'h1;

    localparam int STAB_SHORT_EXP = 15;
    localparam int STAB_LONG_EXP  = 17;
    localparam int STAB_SHORT_CYCLES = 1 << STAB_SHORT_EXP;
    localparam int STAB_LONG_CYCLES  = 1 << STAB_LONG_EXP;
    localparam int STAB_CNT_W        = STAB_LONG_EXP + 1;

    typedef enum logic [3:0] {
        INS_CALL_ABS,
        INS_CALL_FIXED,
        INS_CALL_EXT,
        INS_BRANCH_EXT,
        INS_RETURN,
        INS_VECTOR,
        INS_RET_INT,
        INS_BANK_SEL,
        INS_BR_GROUP1,
        INS_BR_GROUP2,
        INS_TABLE_GROUP1,
        INS_TABLE_GROUP2,
        INS_BIT_TO_CARRY,
        INS_CARRY_TO_BIT,
        INS_LEGACY
    } instr_t;

endpackage : mark_mode_pkg

// ==== verilog/mark_mode_ctrl.sv ====
/*
 Mark-mode, stack framing, register-bank and status-word control of a
 4-bit core, with its reset-time oscillation wait.
 Assumes a same-clock decoder that presents one classified instruction
 per INSTR_VALID pulse and a datapath that moves the stack bytes.
*/
`timescale 1ns/1ps
module mark_mode_ctrl #(
    parameter logic STAB_LONG         = 1'b1,
    parameter int   STAB_SHORT_CYCLES = mark_mode_pkg::STAB_SHORT_CYCLES,
    parameter int   STAB_LONG_CYCLES  = mark_mode_pkg::STAB_LONG_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic [11:0] ADDR,
    input  wire logic [3:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [3:0]  RDATA,
    input  wire logic        INSTR_VALID,
    input  wire logic [3:0]  INSTR_CODE,
    input  wire logic [1:0]  INSTR_OPERAND,
    input  wire logic [3:0]  REG_B,
    input  wire logic [3:0]  REG_C,
    input  wire logic [3:0]  REG_D,
    input  wire logic [3:0]  REG_E,
    input  wire logic [3:0]  REG_X,
    input  wire logic [3:0]  REG_A,
    input  wire logic        BIT_IN,
    input  wire logic        POP_BANK_EN,
    input  wire logic        VECTOR_BANK_EN,
    output logic             READY,
    output logic             DONE,
    output logic             ILLEGAL,
    output logic      [2:0]  EXEC_CYCLES,
    output logic      [1:0]  FRAME_BYTES,
    output logic      [7:0]  STACK_PTR,
    output logic      [1:0]  STACK_BANK,
    output logic             LARGE_MODE,
    output logic      [1:0]  ACTIVE_BANK,
    output logic      [15:0] JUMP_ADDR,
    output logic             JUMP,
    output logic             TABLE_READ,
    output logic             PUSH_BANK_EN,
    output logic             BIT_OUT,
    output logic             CARRY,
    output logic             INT_STATUS
);

    typedef struct packed {
        logic [3:0]                            stack_bank_reg;
        logic [3:0]                            bank_select_reg;
        logic                                  carry_flag;
        logic                                  bank_enable_bit;
        logic                                  interrupt_status_bit;
        logic [7:0]                            sp;
        logic [mark_mode_pkg::STAB_CNT_W-1:0]  stab_cnt;
        logic                                  ready;
        logic                                  done;
        logic                                  illegal;
        logic [2:0]                            cycles;
        logic [1:0]                            frame;
        logic [15:0]                           target;
        logic                                  jump;
        logic                                  table_read;
        logic                                  push_bank_en;
        logic                                  bit_out;
        logic [3:0]                            rdata;
    } state_t;

    localparam int STAB_CYCLES = STAB_LONG ? STAB_LONG_CYCLES
                                           : STAB_SHORT_CYCLES;
    localparam logic [mark_mode_pkg::STAB_CNT_W-1:0] STAB_LAST =
        mark_mode_pkg::STAB_CNT_W'(STAB_CYCLES - 1);

    localparam state_t RESET_STATE = '{
        stack_bank_reg:       mark_mode_pkg::STACK_BANK_RESET,
        bank_select_reg:      mark_mode_pkg::BANK_SEL_RESET,
        sp:                   mark_mode_pkg::SP_RESET,
        frame:                mark_mode_pkg::SMALL_FRAME,
        cycles:               mark_mode_pkg::OTHER_CYCLES,
        default:              '0
    };

    state_t st;
    state_t next_st;

    // Frame size follows the mode bit at the moment of the call or return
    function automatic logic [1:0] frame_of(input logic small_mode);
        frame_of = small_mode ? mark_mode_pkg::SMALL_FRAME
                              : mark_mode_pkg::LARGE_FRAME;
    endfunction : frame_of

    function automatic logic [15:0] pair_addr(input logic group_two,
                                              input logic [3:0] b,
                                              input logic [3:0] c,
                                              input logic [3:0] d,
                                              input logic [3:0] e,
                                              input logic [3:0] x,
                                              input logic [3:0] a);
        pair_addr = group_two ? {b, c, x, a} : {b, c, d, e};
    endfunction : pair_addr

    logic       small_mode;
    logic       take;
    logic [3:0] psw_view;

    assign small_mode = st.stack_bank_reg[mark_mode_pkg::MODE_BIT];
    assign take       = INSTR_VALID && st.ready;

    always_comb
    begin
        psw_view = 4'h0;
        psw_view[mark_mode_pkg::PSW_CARRY]   = st.carry_flag;
        psw_view[mark_mode_pkg::PSW_IST]     = st.interrupt_status_bit;
        psw_view[mark_mode_pkg::PSW_BANK_EN] = st.bank_enable_bit;
    end

    always_comb
    begin
        next_st            = st;
        next_st.done       = 1'b0;
        next_st.illegal    = 1'b0;
        next_st.jump       = 1'b0;
        next_st.table_read = 1'b0;
        next_st.rdata      = 4'h0;

        if (!st.ready)
        begin
            if (st.stab_cnt == STAB_LAST)
                next_st.ready = 1'b1;
            else
                next_st.stab_cnt = st.stab_cnt + 1'b1;
        end

        if (RD)
        begin
            unique case (ADDR)
                mark_mode_pkg::ADDR_SP_LOW:     next_st.rdata = st.sp[3:0];
                mark_mode_pkg::ADDR_SP_HIGH:    next_st.rdata = st.sp[7:4];
                mark_mode_pkg::ADDR_BANK_SEL:
                    next_st.rdata = st.bank_select_reg;
                mark_mode_pkg::ADDR_STACK_BANK:
                    next_st.rdata = st.stack_bank_reg;
                mark_mode_pkg::ADDR_PSW:        next_st.rdata = psw_view;
                default:                        next_st.rdata = 4'h0;
            endcase
        end

        if (WR)
        begin
            unique case (ADDR)
                mark_mode_pkg::ADDR_SP_LOW:     next_st.sp[3:0] = WDATA;
                mark_mode_pkg::ADDR_SP_HIGH:    next_st.sp[7:4] = WDATA;
                mark_mode_pkg::ADDR_BANK_SEL:
                    next_st.bank_select_reg = WDATA;
                mark_mode_pkg::ADDR_STACK_BANK: next_st.stack_bank_reg = WDATA;
                mark_mode_pkg::ADDR_PSW:
                begin
                    // Interrupt status is hardware-owned and ignores writes
                    next_st.carry_flag = WDATA[mark_mode_pkg::PSW_CARRY];
                    next_st.bank_enable_bit =
                        WDATA[mark_mode_pkg::PSW_BANK_EN];
                end
                default: ;
            endcase
        end

        // Instruction effects come last so they win over a same-cycle write
        if (take)
        begin
            next_st.done   = 1'b1;
            next_st.cycles = mark_mode_pkg::OTHER_CYCLES;
            next_st.frame  = frame_of(small_mode);
            unique case (INSTR_CODE)
                mark_mode_pkg::INS_CALL_ABS,
                mark_mode_pkg::INS_CALL_FIXED,
                mark_mode_pkg::INS_CALL_EXT:
                begin
                    if (INSTR_CODE == mark_mode_pkg::INS_CALL_EXT &&
                        small_mode)
                    begin
                        next_st.illegal = 1'b1;
                        next_st.done    = 1'b0;
                    end
                    else
                    begin
                        if (INSTR_CODE == mark_mode_pkg::INS_CALL_ABS ||
                            INSTR_CODE == mark_mode_pkg::INS_CALL_EXT)
                            next_st.cycles = small_mode ?
                                mark_mode_pkg::CALL_SMALL_CYCLES :
                                mark_mode_pkg::CALL_LARGE_CYCLES;
                        else
                            next_st.cycles = small_mode ?
                                mark_mode_pkg::FCALL_SMALL_CYCLES :
                                mark_mode_pkg::FCALL_LARGE_CYCLES;
                        next_st.sp = st.sp - {6'h00, frame_of(small_mode)};
                        next_st.push_bank_en = st.bank_enable_bit;
                    end
                end
                mark_mode_pkg::INS_BRANCH_EXT:
                begin
                    if (small_mode)
                    begin
                        next_st.illegal = 1'b1;
                        next_st.done    = 1'b0;
                    end
                    else
                    begin
                        next_st.jump   = 1'b1;
                        next_st.target = {REG_B, REG_C, REG_D, REG_E};
                    end
                end
                mark_mode_pkg::INS_RETURN,
                mark_mode_pkg::INS_RET_INT:
                begin
                    next_st.sp = st.sp + {6'h00, frame_of(small_mode)};
                    next_st.bank_enable_bit = POP_BANK_EN;
                    if (INSTR_CODE == mark_mode_pkg::INS_RET_INT)
                        next_st.interrupt_status_bit = 1'b0;
                end
                mark_mode_pkg::INS_VECTOR:
                begin
                    next_st.sp = st.sp - {6'h00, frame_of(small_mode)};
                    next_st.push_bank_en = st.bank_enable_bit;
                    next_st.bank_enable_bit = VECTOR_BANK_EN;
                    next_st.interrupt_status_bit = 1'b1;
                end
                mark_mode_pkg::INS_BANK_SEL:
                    next_st.bank_select_reg = {2'b00, INSTR_OPERAND};
                mark_mode_pkg::INS_BR_GROUP1,
                mark_mode_pkg::INS_BR_GROUP2:
                begin
                    next_st.jump   = 1'b1;
                    next_st.target = pair_addr(
                        INSTR_CODE == mark_mode_pkg::INS_BR_GROUP2,
                        REG_B, REG_C, REG_D, REG_E, REG_X, REG_A);
                end
                mark_mode_pkg::INS_TABLE_GROUP1,
                mark_mode_pkg::INS_TABLE_GROUP2:
                begin
                    next_st.table_read = 1'b1;
                    next_st.target     = pair_addr(
                        INSTR_CODE == mark_mode_pkg::INS_TABLE_GROUP2,
                        REG_B, REG_C, REG_D, REG_E, REG_X, REG_A);
                end
                mark_mode_pkg::INS_BIT_TO_CARRY: next_st.carry_flag = BIT_IN;
                mark_mode_pkg::INS_CARRY_TO_BIT:
                    next_st.bit_out = st.carry_flag;
                mark_mode_pkg::INS_LEGACY: ;
                default:
                begin
                    next_st.illegal = 1'b1;
                    next_st.done    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RESET)
            st <= RESET_STATE;
        else
            st <= next_st;
    end

    assign RDATA        = st.rdata;
    assign READY        = st.ready;
    assign DONE         = st.done;
    assign ILLEGAL      = st.illegal;
    assign EXEC_CYCLES  = st.cycles;
    assign FRAME_BYTES  = st.frame;
    assign STACK_PTR    = st.sp;
    assign STACK_BANK   = st.stack_bank_reg[1:0];
    assign LARGE_MODE   = !small_mode;
    assign ACTIVE_BANK  = st.bank_enable_bit ? st.bank_select_reg[1:0]
                                             : 2'b00;
    assign JUMP_ADDR    = st.target;
    assign JUMP         = st.jump;
    assign TABLE_READ   = st.table_read;
    assign PUSH_BANK_EN = st.push_bank_en;
    assign BIT_OUT      = st.bit_out;
    assign CARRY        = st.carry_flag;
    assign INT_STATUS   = st.interrupt_status_bit;

    a_reset_stack_bank: assert property (@(posedge CORE_CLK)
        RESET |=> (st.stack_bank_reg == 4'h8 && LARGE_MODE == 1'b0))
        else $error("stack bank not 1000b after reset");

    a_call_abs_cycles: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h0) |=>
        (EXEC_CYCLES == ($past(small_mode) ? 3'h3 : 3'h4)))
        else $error("absolute call cycle count wrong");

    a_call_fix_cycles: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h1) |=>
        (EXEC_CYCLES == ($past(small_mode) ? 3'h2 : 3'h3)))
        else $error("fixed-area call cycle count wrong");

    a_call_frame_push: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h0 && !WR) |=>
        (STACK_PTR == $past(st.sp) - ($past(small_mode) ? 8'h02 : 8'h03)))
        else $error("call frame size wrong");

    a_ret_frame_pop: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h4 && !WR) |=>
        (STACK_PTR == $past(st.sp) + ($past(small_mode) ? 8'h02 : 8'h03)))
        else $error("return frame size wrong");

    a_ext_refused: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && small_mode &&
         (INSTR_CODE == 4'h2 || INSTR_CODE == 4'h3)) |=>
        (ILLEGAL && !DONE && !JUMP && STACK_PTR == $past(st.sp)))
        else $error("extended instruction ran in small mode");

    a_vector_bank_en: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h5) |=>
        (st.bank_enable_bit == $past(VECTOR_BANK_EN) && INT_STATUS))
        else $error("vector did not load bank enable");

    a_pair_target: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'h9) |=>
        (JUMP && JUMP_ADDR == {$past(REG_B), $past(REG_C),
                               $past(REG_X), $past(REG_A)}))
        else $error("group-two branch address wrong");

    a_carry_move: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (take && INSTR_CODE == 4'hc) |=> (CARRY == $past(BIT_IN)))
        else $error("bit move into carry lost");

    a_wait_blocks: assert property (@(posedge CORE_CLK)
        disable iff (RESET)
        (!READY && INSTR_VALID) |=> (!DONE && !ILLEGAL))
        else $error("instruction taken before stabilization");

endmodule : mark_mode_ctrl

// ==== dv/cpu_mark_mode_stack_control_bench.sv ====
/*
 Self-checking bench for the mark-mode, stack and register-bank control.
 Assumes the design runs with shortened reset waits (8/16 cycles) and
 that the bench alone drives the register port and instruction requests.
*/
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            $display("FAIL %s expected %0h seen %0h", what, exp, got); \
            error_cnt++; \
        end \
    end
module cpu_mark_mode_stack_control_bench;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [3:0]  wdata = 4'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [3:0]  rdata;
    logic        instr_valid = 1'b0;
    logic [3:0]  instr_code = 4'h0;
    logic [1:0]  instr_operand = 2'h0;
    logic        bit_in = 1'b0;
    logic        pop_bank_en = 1'b0;
    logic        vector_bank_en = 1'b0;
    logic [3:0]  reg_b = 4'h1, reg_c = 4'h2, reg_d = 4'h3;
    logic [3:0]  reg_e = 4'h4, reg_x = 4'h5, reg_a = 4'h6;
    logic        ready, done, illegal, large_mode, jump, table_read;
    logic        push_bank_en, bit_out, carry, int_status;
    logic [2:0]  exec_cycles;
    logic [1:0]  frame_bytes, stack_bank, active_bank;
    logic [7:0]  stack_ptr;
    logic [15:0] jump_addr;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #5 core_clk = ~core_clk;

    mark_mode_ctrl #(.STAB_LONG(1'b0), .STAB_SHORT_CYCLES(8),
                     .STAB_LONG_CYCLES(16)) dut (
        .CORE_CLK(core_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .INSTR_VALID(instr_valid),
        .INSTR_CODE(instr_code), .INSTR_OPERAND(instr_operand),
        .REG_B(reg_b), .REG_C(reg_c), .REG_D(reg_d), .REG_E(reg_e),
        .REG_X(reg_x), .REG_A(reg_a), .BIT_IN(bit_in),
        .POP_BANK_EN(pop_bank_en), .VECTOR_BANK_EN(vector_bank_en),
        .READY(ready), .DONE(done), .ILLEGAL(illegal),
        .EXEC_CYCLES(exec_cycles), .FRAME_BYTES(frame_bytes),
        .STACK_PTR(stack_ptr), .STACK_BANK(stack_bank),
        .LARGE_MODE(large_mode), .ACTIVE_BANK(active_bank),
        .JUMP_ADDR(jump_addr), .JUMP(jump), .TABLE_READ(table_read),
        .PUSH_BANK_EN(push_bank_en), .BIT_OUT(bit_out), .CARRY(carry),
        .INT_STATUS(int_status));

    task automatic stop_test();
        $display("Counts: %0d comparisons, %0d errors", comparisons,
                 error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // A hang anywhere ends the run through the same report
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic reg_write(input logic [11:0] a, input logic [3:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] a, output logic [3:0] d);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_read

    // Results are looked at in the cycle of the DONE or ILLEGAL pulse
    task automatic run_instr(input logic [3:0] code);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_code <= code;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : run_instr

    task automatic check_reset_state();
        logic [3:0] d;
        `CHK("large_mode", 1'b0, large_mode);
        `CHK("stack_bank", 2'h0, stack_bank);
        reg_read(mark_mode_pkg::ADDR_STACK_BANK, d);
        `CHK("stack bank reg", 4'h8, d);
        reg_read(12'hf86, d);
        `CHK("unmapped read", 4'h0, d);
        // Requests before the oscillation wait ends must be ignored
        run_instr(mark_mode_pkg::INS_CALL_ABS);
        `CHK("early done", 1'b0, done);
        `CHK("early sp", 8'h00, stack_ptr);
    endtask : check_reset_state

    task automatic small_mode_calls();
        reg_write(mark_mode_pkg::ADDR_SP_LOW, 4'h1);
        run_instr(mark_mode_pkg::INS_CALL_ABS);
        `CHK("call done", 1'b1, done);
        `CHK("call cycles", 3'h3, exec_cycles);
        `CHK("call frame", 2'h2, frame_bytes);
        `CHK("sp wrap", 8'hff, stack_ptr);
        run_instr(mark_mode_pkg::INS_CALL_FIXED);
        `CHK("fcall cycles", 3'h2, exec_cycles);
        `CHK("fcall sp", 8'hfd, stack_ptr);
        run_instr(mark_mode_pkg::INS_CALL_EXT);
        `CHK("ext call refused", 1'b1, illegal);
        `CHK("ext call sp", 8'hfd, stack_ptr);
        run_instr(mark_mode_pkg::INS_BRANCH_EXT);
        `CHK("ext branch refused", 1'b1, illegal);
        `CHK("ext branch jump", 1'b0, jump);
        run_instr(mark_mode_pkg::INS_RETURN);
        run_instr(mark_mode_pkg::INS_RETURN);
        `CHK("return sp", 8'h01, stack_ptr);
    endtask : small_mode_calls

    task automatic large_mode_calls();
        reg_write(mark_mode_pkg::ADDR_STACK_BANK, 4'h1);
        `CHK("large_mode", 1'b1, large_mode);
        `CHK("stack_bank", 2'h1, stack_bank);
        run_instr(mark_mode_pkg::INS_CALL_ABS);
        `CHK("call cycles", 3'h4, exec_cycles);
        `CHK("call frame", 2'h3, frame_bytes);
        `CHK("call sp", 8'hfe, stack_ptr);
        run_instr(mark_mode_pkg::INS_CALL_FIXED);
        `CHK("fcall cycles", 3'h3, exec_cycles);
        run_instr(mark_mode_pkg::INS_CALL_EXT);
        `CHK("ext call done", 1'b1, done);
        `CHK("ext call sp", 8'hf8, stack_ptr);
        run_instr(mark_mode_pkg::INS_BRANCH_EXT);
        `CHK("ext branch jump", 1'b1, jump);
        `CHK("ext branch addr", 16'h1234, jump_addr);
        run_instr(mark_mode_pkg::INS_RETURN);
        `CHK("return sp", 8'hfb, stack_ptr);
    endtask : large_mode_calls

    task automatic pair_addressing();
        run_instr(mark_mode_pkg::INS_BR_GROUP1);
        `CHK("group one branch", 16'h1234, jump_addr);
        `CHK("group one jump", 1'b1, jump);
        run_instr(mark_mode_pkg::INS_BR_GROUP2);
        `CHK("group two branch", 16'h1256, jump_addr);
        run_instr(mark_mode_pkg::INS_TABLE_GROUP1);
        `CHK("group one table", 16'h1234, jump_addr);
        `CHK("table pulse", 1'b1, table_read);
        run_instr(mark_mode_pkg::INS_TABLE_GROUP2);
        `CHK("group two table", 16'h1256, jump_addr);
        reg_d <= 4'hc;
        reg_x <= 4'ha;
        reg_a <= 4'hb;
        run_instr(mark_mode_pkg::INS_BR_GROUP2);
        `CHK("group two new pair", 16'h12ab, jump_addr);
        run_instr(mark_mode_pkg::INS_BR_GROUP1);
        `CHK("group one new pair", 16'h12c4, jump_addr);
        run_instr(mark_mode_pkg::INS_LEGACY);
        `CHK("legacy done", 1'b1, done);
        `CHK("legacy cycles", 3'h1, exec_cycles);
        run_instr(4'hf);
        `CHK("undefined refused", 1'b1, illegal);
    endtask : pair_addressing

    task automatic banks_and_status();
        logic [3:0] d;
        reg_write(mark_mode_pkg::ADDR_BANK_SEL, 4'h2);
        `CHK("bank with enable off", 2'h0, active_bank);
        reg_write(mark_mode_pkg::ADDR_PSW, 4'h8);
        `CHK("bank from register", 2'h2, active_bank);
        instr_operand <= 2'h3;
        run_instr(mark_mode_pkg::INS_BANK_SEL);
        `CHK("bank from instruction", 2'h3, active_bank);
        reg_read(mark_mode_pkg::ADDR_BANK_SEL, d);
        `CHK("bank reg read", 4'h3, d);
        bit_in <= 1'b1;
        run_instr(mark_mode_pkg::INS_BIT_TO_CARRY);
        `CHK("carry loaded", 1'b1, carry);
        run_instr(mark_mode_pkg::INS_CARRY_TO_BIT);
        `CHK("carry copied", 1'b1, bit_out);
        // Status bit is read-only and bit 2 always reads back as zero
        reg_write(mark_mode_pkg::ADDR_PSW, 4'hf);
        reg_read(mark_mode_pkg::ADDR_PSW, d);
        `CHK("status word", 4'h9, d);
        run_instr(mark_mode_pkg::INS_VECTOR);
        `CHK("vector status", 1'b1, int_status);
        `CHK("saved enable", 1'b1, push_bank_en);
        `CHK("vector enable off", 2'h0, active_bank);
        `CHK("vector sp", 8'hf8, stack_ptr);
        pop_bank_en <= 1'b1;
        run_instr(mark_mode_pkg::INS_RET_INT);
        `CHK("status cleared", 1'b0, int_status);
        `CHK("enable restored", 2'h3, active_bank);
        `CHK("ret_int sp", 8'hfb, stack_ptr);
    endtask : banks_and_status

    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        `CHK("ready at release", 1'b0, ready);
        check_reset_state();
        // Eight-cycle wait: still low after the seventh edge past release
        @(posedge core_clk);
        #1;
        `CHK("ready one early", 1'b0, ready);
        @(posedge core_clk);
        #1;
        `CHK("ready", 1'b1, ready);
        small_mode_calls();
        large_mode_calls();
        pair_addressing();
        banks_and_status();
        stop_test();
    end
endmodule : cpu_mark_mode_stack_control_bench
